// ===== core/epc_defs.svh
// Offsets, field positions, reset values for the core event unit.
// Assumes inclusion by bare name from every design file that needs it.
// Function
// - Five event classes, each own path
// - Fixed levels, lower number ranks higher
// - Nested service routines stay active together
// - Higher priority event always served first
// - Emulation event enters emulation mode
// - Reset event resets whole processor
// - Non-maskable from watchdog or pin
// - Exception taken before instruction completes
// - Misalign or undefined opcode raise exception
// - Interrupts from pins, timers, peripherals, software
// - Per-level return address and return
// - Taking event saves state on stack
// - Peripheral interrupts arrive via router stage
// - Nine general inputs at levels 7-15
// - Latch set on event, cleared on accept
// - Mask bit set lets latched event serve
// - Active bit set while routine runs
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EPC_OFF_LATCH   8'h00
`define EPC_OFF_MASK    8'h04
`define EPC_OFF_ACTIVE  8'h08
`define EPC_OFF_CTRL    8'h0C
`define EPC_OFF_ISTAT   8'h10
`define EPC_OFF_EVENT_MASK_REG   8'h14
`define EPC_RET_PAGE    2'h1

// ----------------------------------------
// Levels and fixed bit groups
// ----------------------------------------
`define EPC_LVL_EMU     4'h0
`define EPC_LVL_RST     4'h1
`define EPC_LVL_NMI     4'h2
`define EPC_LVL_EXC     4'h3
`define EPC_LVL_RSVD    4'h4
`define EPC_LVL_HWE     4'h5
`define EPC_LVL_TMR     4'h6
`define EPC_LVL_GP0     4'h7
`define EPC_ALWAYS_ON   16'h000F
`define EPC_RSVD_BITS   16'h0010
`define EPC_GP_BITS     16'hFF80

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define EPC_CTRL_GPEN   0
`define EPC_CTRL_SRST   1
`define EPC_IS_TAKE     0
`define EPC_IS_REFUSE   1
`define EPC_IS_STRAY    2
`define EPC_IS_W        3
`define EPC_LATCH_RST   16'h0000
`define EPC_MASK_RST    16'h0000
`define EPC_GPEN_RST    1'h1
`define EPC_RESP_OKAY   2'h0
`define EPC_RESP_SLVERR 2'h2

`endif

// ===== core/epc_pkg.sv
// Types shared by the core event unit files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package epc_pkg;
  typedef logic [3:0]  epc_lvl_t;
  typedef logic [15:0] epc_vec_t;
  typedef logic [31:0] epc_word_t;
  typedef logic [1:0]  epc_resp_t;
endpackage : epc_pkg
`default_nettype wire

// ===== core/epc_pin_sync.sv
// Three-stage pin filter with registered rising-edge flag per bit.
// Assumes pins asynchronous to clk; ce freezes all stages.
`default_nettype none
module epc_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] level_q,
  output var  logic [W-1:0] rise_q
);
  generate
    if (W < 1) begin : g_bad
      $error("epc_pin_sync needs W of at least 1");
    end
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q       <= 1'b0;
          s2_q       <= 1'b0;
          s3_q       <= 1'b0;
          level_q[i] <= 1'b0;
          rise_q[i]  <= 1'b0;
        end else if (ce) begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Change counts only once stages two and three agree
          if (s2_q == s3_q) begin
            level_q[i] <= s3_q;
          end
          rise_q[i] <= (s2_q == s3_q) && s3_q && !level_q[i];
        end
      end
    end
  endgenerate
endmodule : epc_pin_sync
`default_nettype wire

// ===== core/epc_prio_pick.sv
// Lowest-index set bit finder: index zero ranks highest.
// Assumes a purely combinational use on the caller's clock.
`default_nettype none
module epc_prio_pick #(
  parameter int N  = 16,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]  vec,
  output var  logic [IW-1:0] idx,
  output var  logic          any
);
  generate
    if ((1 << IW) < N) begin : g_bad
      $error("epc_prio_pick index too narrow");
    end
  endgenerate

  always_comb begin
    idx = '0;
    any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = IW'(i);
        any = 1'b1;
      end
    end
  end
endmodule : epc_prio_pick
`default_nettype wire

// ===== core/epc_core_event_unit.sv
// Core event unit: latch, mask, active tracking, nesting, AXI4-Lite regs.
// Assumes the sequencer, router and watchdog share clk with this block.
`default_nettype none
`include "epc_defs.svh"
module epc_core_event_unit #(
  parameter int AW     = 8,
  parameter int NUM_GP = 9
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                ce,
  input  wire logic [AW-1:0]       s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  epc_pkg::epc_resp_t  s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AW-1:0]       s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  epc_pkg::epc_word_t  s_axi_rdata,
  output var  epc_pkg::epc_resp_t  s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                emu_req_pin,
  input  wire logic                nmi_pin,
  input  wire logic                wdog_nmi_req,
  input  wire logic                exc_req,
  input  wire logic                hw_err_req,
  input  wire logic                core_timer_req,
  input  wire logic [NUM_GP-1:0]   gp_irq,
  input  wire logic                sw_raise_valid,
  input  wire epc_pkg::epc_lvl_t   sw_raise_level,
  input  wire epc_pkg::epc_word_t  ret_pc,
  input  wire logic                rte_valid,
  input  wire epc_pkg::epc_lvl_t   rte_level,
  output var  logic                take_valid_q,
  output var  epc_pkg::epc_lvl_t   take_level_q,
  output var  logic                push_state_q,
  output var  logic                exc_abort_q,
  output var  logic                emu_mode_q,
  output var  logic                core_reset_q,
  output var  logic                resume_valid_q,
  output var  epc_pkg::epc_word_t  resume_addr_q,
  output var  logic                irq_q
);
  localparam int LVLS = 16;

  generate
    if (NUM_GP + 7 != LVLS) begin : g_bad_gp
      $error("Nine general inputs fill levels 7 to 15");
    end
    if (AW < 8) begin : g_bad_aw
      $error("AXI address must be at least 8 bits");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  epc_pkg::epc_vec_t  latch_q;
  epc_pkg::epc_vec_t  mask_q;
  epc_pkg::epc_vec_t  active_q;
  logic               gp_en_q;
  logic [`EPC_IS_W-1:0] istat_q;
  logic [`EPC_IS_W-1:0] event_mask_reg_q;
  epc_pkg::epc_word_t ret_addr_q [LVLS];
  logic [AW-1:0]      awaddr_q;
  epc_pkg::epc_word_t wdata_q;
  logic [3:0]         wstrb_q;

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic [1:0] pin_rise;
  logic [1:0] pin_level;

  epc_pin_sync #(.W(2)) u_pins (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin     ({nmi_pin, emu_req_pin}),
    .level_q (pin_level),
    .rise_q  (pin_rise)
  );

  logic              wr_fire;
  logic              wr_latch;
  logic              wr_mask;
  logic              wr_ctrl;
  logic              wr_istat;
  logic              wr_event_mask_reg;
  logic              srst_req;
  epc_pkg::epc_vec_t lane16;
  epc_pkg::epc_vec_t wdata16;
  epc_pkg::epc_vec_t sw_vec;
  epc_pkg::epc_vec_t set_vec;

  assign lane16  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wdata16 = wdata_q[15:0];
  assign srst_req = wr_ctrl && wstrb_q[0] && wdata_q[`EPC_CTRL_SRST];

  always_comb begin
    sw_vec = '0;
    if (sw_raise_valid && sw_raise_level >= `EPC_LVL_GP0) begin
      sw_vec[sw_raise_level] = 1'b1;
    end
  end

  always_comb begin
    set_vec = '0;
    set_vec[`EPC_LVL_EMU] = pin_rise[0];
    set_vec[`EPC_LVL_RST] = srst_req;
    set_vec[`EPC_LVL_NMI] = wdog_nmi_req || pin_rise[1];
    set_vec[`EPC_LVL_EXC] = exc_req;
    set_vec[`EPC_LVL_HWE] = hw_err_req;
    set_vec[`EPC_LVL_TMR] = core_timer_req;
    set_vec[LVLS-1:7] = gp_irq | sw_vec[LVLS-1:7];
  end

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  epc_pkg::epc_vec_t mask_eff;
  epc_pkg::epc_vec_t cand;
  epc_pkg::epc_lvl_t c_lvl;
  epc_pkg::epc_lvl_t a_lvl;
  logic              c_any;
  logic              a_any;
  logic              take;
  epc_pkg::epc_vec_t take_vec;
  epc_pkg::epc_vec_t rte_vec;
  logic              stray;

  assign mask_eff = (mask_q | `EPC_ALWAYS_ON) & ~`EPC_RSVD_BITS;
  assign cand = latch_q & mask_eff
              & (gp_en_q ? 16'hFFFF : ~`EPC_GP_BITS);

  epc_prio_pick #(.N(LVLS), .IW(4)) u_pick_cand (
    .vec (cand),
    .idx (c_lvl),
    .any (c_any)
  );

  epc_prio_pick #(.N(LVLS), .IW(4)) u_pick_act (
    .vec (active_q),
    .idx (a_lvl),
    .any (a_any)
  );

  // Preempt only above the highest active routine
  assign take = c_any && (!a_any || c_lvl < a_lvl);
  assign take_vec = take ? (16'h0001 << c_lvl) : '0;
  assign rte_vec  = rte_valid ? (16'h0001 << rte_level) : '0;
  assign stray    = rte_valid && !active_q[rte_level];

  // ----------------------------------------
  // Latch, mask and active registers
  // ----------------------------------------
  epc_pkg::epc_vec_t lat_wm;
  logic              refuse;

  assign lat_wm = wr_latch ? (lane16 & ~mask_eff & ~`EPC_RSVD_BITS) : '0;
  assign refuse = wr_latch
                && |(lane16 & mask_eff & (wdata16 ^ latch_q));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= `EPC_LATCH_RST;
    end else if (ce) begin
      // New event wins over accept and software clear
      latch_q <= (((latch_q & ~lat_wm) | (wdata16 & lat_wm))
                 & ~take_vec) | set_vec;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q  <= `EPC_MASK_RST;
      gp_en_q <= `EPC_GPEN_RST;
    end else if (ce) begin
      if (wr_mask) begin
        mask_q <= (mask_q & ~lane16) | (wdata16 & lane16);
      end
      if (wr_ctrl && wstrb_q[0]) begin
        gp_en_q <= wdata_q[`EPC_CTRL_GPEN];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= '0;
    end else if (ce) begin
      if (take && c_lvl == `EPC_LVL_RST) begin
        active_q <= take_vec;
      end else begin
        active_q <= (active_q & ~rte_vec) | take_vec;
      end
    end
  end

  // ----------------------------------------
  // Sequencer handshake
  // ----------------------------------------
  generate
    for (genvar i = 0; i < LVLS; i++) begin : g_ret
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ret_addr_q[i] <= '0;
        end else if (ce && take && c_lvl == 4'(i)) begin
          ret_addr_q[i] <= ret_pc;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      take_valid_q   <= 1'b0;
      take_level_q   <= '0;
      push_state_q   <= 1'b0;
      exc_abort_q    <= 1'b0;
      core_reset_q   <= 1'b0;
      resume_valid_q <= 1'b0;
      resume_addr_q  <= '0;
    end else if (ce) begin
      take_valid_q   <= take;
      push_state_q   <= take;
      exc_abort_q    <= exc_req;
      core_reset_q   <= take && c_lvl == `EPC_LVL_RST;
      resume_valid_q <= rte_valid;
      if (take) begin
        take_level_q <= c_lvl;
      end
      if (rte_valid) begin
        resume_addr_q <= ret_addr_q[rte_level];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      emu_mode_q <= 1'b0;
    end else if (ce) begin
      if (take && c_lvl == `EPC_LVL_EMU) begin
        emu_mode_q <= 1'b1;
      end else if (rte_valid && rte_level == `EPC_LVL_EMU) begin
        emu_mode_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [`EPC_IS_W-1:0] ev;
  logic [`EPC_IS_W-1:0] istat_d;
  logic [`EPC_IS_W-1:0] event_mask_reg_d;

  assign ev = {stray, refuse, take};
  assign istat_d = (istat_q & ~(wr_istat && wstrb_q[0]
                   ? wdata_q[`EPC_IS_W-1:0] : '0)) | ev;
  assign event_mask_reg_d = (wr_event_mask_reg && wstrb_q[0])
                 ? wdata_q[`EPC_IS_W-1:0] : event_mask_reg_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_q <= '0;
      event_mask_reg_q <= '0;
      irq_q   <= 1'b0;
    end else if (ce) begin
      istat_q <= istat_d;
      event_mask_reg_q <= event_mask_reg_d;
      irq_q   <= |(istat_d & event_mask_reg_d);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  logic wr_hit;

  assign wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_latch = wr_fire && awaddr_q == AW'(`EPC_OFF_LATCH);
  assign wr_mask  = wr_fire && awaddr_q == AW'(`EPC_OFF_MASK);
  assign wr_ctrl  = wr_fire && awaddr_q == AW'(`EPC_OFF_CTRL);
  assign wr_istat = wr_fire && awaddr_q == AW'(`EPC_OFF_ISTAT);
  assign wr_event_mask_reg = wr_fire && awaddr_q == AW'(`EPC_OFF_EVENT_MASK_REG);
  assign wr_hit = wr_latch || wr_mask || wr_ctrl || wr_istat || wr_event_mask_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPC_RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  epc_pkg::epc_word_t rd_val;
  logic               rd_hit;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr[AW-1:6] == (AW-6)'(`EPC_RET_PAGE)) begin
      rd_val = ret_addr_q[s_axi_araddr[5:2]];
    end else begin
      unique case (s_axi_araddr)
        AW'(`EPC_OFF_LATCH):  rd_val = {16'h0000, latch_q};
        AW'(`EPC_OFF_MASK):   rd_val = {16'h0000, mask_eff};
        AW'(`EPC_OFF_ACTIVE): rd_val = {16'h0000, active_q};
        AW'(`EPC_OFF_CTRL):   rd_val = {31'h0, gp_en_q};
        AW'(`EPC_OFF_ISTAT):  rd_val = {29'h0, istat_q};
        AW'(`EPC_OFF_EVENT_MASK_REG):  rd_val = {29'h0, event_mask_reg_q};
        default:              rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `EPC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  epc_pkg::epc_vec_t below_c;
  assign below_c = (16'h0001 << c_lvl) - 16'h0001;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_taken;
    ce && take;
  endsequence
  sequence s_wr_go;
    ce && wr_fire;
  endsequence

  property p_pick;
    s_taken |-> (cand & below_c) == 16'h0000;
  endproperty
  property p_nest;
    s_taken ##0 a_any |-> c_lvl < a_lvl;
  endproperty
  property p_mark;
    s_taken |=> take_valid_q && active_q[take_level_q];
  endproperty
  property p_gate;
    s_taken |-> mask_eff[c_lvl] && latch_q[c_lvl];
  endproperty
  property p_clr;
    s_taken ##0 (!set_vec[c_lvl] && !lat_wm[c_lvl])
      |=> !latch_q[take_level_q];
  endproperty
  property p_emu;
    s_taken ##0 (c_lvl == `EPC_LVL_EMU) |=> emu_mode_q;
  endproperty
  property p_rst;
    s_taken ##0 (c_lvl == `EPC_LVL_RST)
      |=> core_reset_q && active_q == 16'h0002;
  endproperty
  property p_nmi;
    ce && wdog_nmi_req |=> latch_q[`EPC_LVL_NMI];
  endproperty
  property p_exc;
    ce && exc_req |=> exc_abort_q && latch_q[`EPC_LVL_EXC];
  endproperty
  property p_push;
    s_taken |=> push_state_q ##0 $past(ret_pc) == ret_addr_q[take_level_q];
  endproperty
  property p_bresp;
    s_wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty

  a_pick:  assert property (p_pick)  else $error("higher level skipped");
  a_nest:  assert property (p_nest)  else $error("no preemption rank");
  a_mark:  assert property (p_mark)  else $error("active bit missing");
  a_gate:  assert property (p_gate)  else $error("masked event served");
  a_clr:   assert property (p_clr)   else $error("latch not cleared");
  a_emu:   assert property (p_emu)   else $error("no emulation mode");
  a_rst:   assert property (p_rst)   else $error("reset event wrong");
  a_nmi:   assert property (p_nmi)   else $error("watchdog nmi lost");
  a_exc:   assert property (p_exc)   else $error("exception not held");
  a_push:  assert property (p_push)  else $error("state not saved");
  a_bresp: assert property (p_bresp) else $error("write not answered");
endmodule : epc_core_event_unit
`default_nettype wire

// ===== dv/epc_seq_model.sv
// Sequencer stand-in: supplies return addresses and issues returns.
// Assumes the event unit's clock and reset; returns come on ret_go.
`default_nettype none
module epc_seq_model (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               take_valid_q,
  input  wire epc_pkg::epc_lvl_t  take_level_q,
  input  wire logic               ret_go,
  output var  logic               rte_valid,
  output var  epc_pkg::epc_lvl_t  rte_level,
  output var  epc_pkg::epc_word_t ret_pc,
  output var  epc_pkg::epc_word_t exp_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  epc_pkg::epc_lvl_t  lvl_q [16];
  epc_pkg::epc_word_t adr_q [16];
  epc_pkg::epc_word_t prev_q;
  int                 sp_q;
  // ----------------------------------------
  // Nesting stack of taken levels
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ret_pc    <= 32'h0000_1000;
      prev_q    <= 32'h0000_0000;
      sp_q      <= 0;
      rte_valid <= 1'b0;
      rte_level <= 4'h0;
      exp_addr  <= 32'h0000_0000;
    end else begin
      // Address seen by the unit at its take edge
      prev_q    <= ret_pc;
      ret_pc    <= ret_pc + 32'h0000_0104;
      rte_valid <= 1'b0;
      if (take_valid_q) begin
        lvl_q[sp_q] <= take_level_q;
        adr_q[sp_q] <= prev_q;
        sp_q        <= sp_q + 1;
      end else if (ret_go && sp_q > 0) begin
        rte_valid <= 1'b1;
        rte_level <= lvl_q[sp_q-1];
        exp_addr  <= adr_q[sp_q-1];
        sp_q      <= sp_q - 1;
      end
    end
  end
endmodule : epc_seq_model
`default_nettype wire

// ===== dv/epc_core_event_unit_tb.sv
// Self-checking bench of the core event unit with AXI4-Lite master.
// Assumes the design files, package and epc_defs.svh are compiled.
`default_nettype none
`include "epc_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module epc_core_event_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, ret_go, rte_valid, sw_raise_valid;
  logic emu_req_pin, nmi_pin, wdog_nmi_req, exc_req, hw_err_req;
  logic core_timer_req, take_valid_q, push_state_q, exc_abort_q;
  logic emu_mode_q, core_reset_q, resume_valid_q, irq_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [8:0]  gp_irq;
  epc_pkg::epc_resp_t s_axi_bresp, s_axi_rresp;
  epc_pkg::epc_word_t s_axi_rdata, ret_pc, resume_addr_q, exp_addr;
  epc_pkg::epc_lvl_t  sw_raise_level, rte_level, take_level_q, lv;
  epc_pkg::epc_lvl_t  tq[$];
  int failures, check_count, n_res, seed, i;
  epc_pkg::epc_lvl_t ev_lvl [4] = '{4'h0, 4'h2, 4'h2, 4'h3};

  epc_core_event_unit i_dut (.clk, .sys_rst, .ce(1'b1),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .emu_req_pin, .nmi_pin, .wdog_nmi_req, .exc_req,
    .hw_err_req, .core_timer_req, .gp_irq, .sw_raise_valid,
    .sw_raise_level, .ret_pc, .rte_valid, .rte_level, .take_valid_q,
    .take_level_q, .push_state_q, .exc_abort_q, .emu_mode_q,
    .core_reset_q, .resume_valid_q, .resume_addr_q, .irq_q);
  epc_seq_model i_seq (.clk, .sys_rst, .take_valid_q, .take_level_q,
    .ret_go, .rte_valid, .rte_level, .ret_pc, .exp_addr);

  // ----------------------------------------
  // Clock, monitor, expectations
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (take_valid_q === 1'b1) begin
      tq.push_back(take_level_q);
      `CHK("push_state", 1'b1, push_state_q)
      if (take_level_q === 4'h1) `CHK("core_reset", 1'b1, core_reset_q)
    end
    if (resume_valid_q === 1'b1) begin
      n_res++;
      `CHK("resume_addr", exp_addr, resume_addr_q)
    end
  end
  function automatic epc_pkg::epc_vec_t lvl_bit(input int l);
    return 16'h0001 << l;
  endfunction : lvl_bit

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    `CHK("bvalid", 1'b1, s_axi_bvalid)
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    `CHK("rvalid", 1'b1, s_axi_rvalid)
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd_chk
  task automatic expect_take(input epc_pkg::epc_lvl_t l);
    int n;
    epc_pkg::epc_lvl_t got;
    n = 0;
    while (tq.size() == 0 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    got = (tq.size() > 0) ? tq.pop_front() : 4'hX;
    `CHK("take_level", l, got)
  endtask : expect_take
  task automatic do_ret();
    int n0;
    n0 = n_res;
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("resume_count", n0 + 1, n_res)
  endtask : do_ret
  task automatic fire(input int k);
    emu_req_pin  <= (k == 0);
    nmi_pin      <= (k == 1);
    wdog_nmi_req <= (k == 2);
    exc_req      <= (k == 3);
    @(posedge clk);
    wdog_nmi_req <= 1'b0;
    exc_req      <= 1'b0;
    #1 if (k == 3) `CHK("exc_abort", 1'b1, exc_abort_q)
    repeat (6) @(posedge clk);
    emu_req_pin <= 1'b0;
    nmi_pin     <= 1'b0;
  endtask : fire
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    #(8 * 20000);
    failures++;
    print_verdict();
  end
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, ret_go, sw_raise_valid} = 4'h0;
    {emu_req_pin, nmi_pin, wdog_nmi_req, exc_req} = 4'h0;
    {hw_err_req, core_timer_req, gp_irq} = 11'h000;
    {s_axi_awaddr, s_axi_araddr, sw_raise_level} = 20'h00000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    seed = 32'h72a54bef;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`EPC_OFF_MASK, 32'h0000_000F, 2'h0);
    rd_chk(`EPC_OFF_CTRL, 32'h0000_0001, 2'h0);
    rd_chk(8'h20, 32'h0000_0000, 2'h2);
    axi_wr(`EPC_OFF_ACTIVE, 32'h0000_FFFF, 2'h2);
    axi_wr(`EPC_OFF_MASK, 32'h0000_FFEF);
    for (i = 0; i < 6; i++) begin
      lv = 4'h7 + 4'({$random(seed)} % 9);
      if (i % 2) lv = 4'hE + 4'($random(seed) & 1);
      gp_irq         <= i[0] ? 9'h000 : 9'h001 << (lv - 4'h7);
      sw_raise_valid <= i[0];
      sw_raise_level <= lv;
      @(posedge clk);
      {gp_irq, sw_raise_valid} <= 10'h000;
      expect_take(lv);
      rd_chk(`EPC_OFF_ACTIVE, lvl_bit(lv), 2'h0);
      do_ret();
    end
    gp_irq <= 9'h100;
    @(posedge clk);
    gp_irq <= 9'h000;
    expect_take(4'hF);
    {hw_err_req, core_timer_req} <= 2'h3;
    @(posedge clk);
    {hw_err_req, core_timer_req} <= 2'h0;
    expect_take(4'h5);
    rd_chk(`EPC_OFF_ACTIVE, 32'h0000_8020, 2'h0);
    repeat (10) @(posedge clk);
    #1 `CHK("no_take", 0, tq.size())
    do_ret();
    expect_take(4'h6);
    rd_chk(`EPC_OFF_ACTIVE, 32'h0000_8040, 2'h0);
    do_ret();
    do_ret();
    rd_chk(`EPC_OFF_ACTIVE, 32'h0000_0000, 2'h0);
    axi_wr(`EPC_OFF_MASK, 32'h0000_FDEF);
    gp_irq <= 9'h004;
    @(posedge clk);
    gp_irq <= 9'h000;
    repeat (10) @(posedge clk);
    #1 `CHK("masked", 0, tq.size())
    rd_chk(`EPC_OFF_LATCH, 32'h0000_0200, 2'h0);
    axi_wr(`EPC_OFF_LATCH, 32'h0000_0000);
    axi_wr(`EPC_OFF_LATCH, 32'h0000_0080);
    rd_chk(`EPC_OFF_LATCH, 32'h0000_0000, 2'h0);
    rd_chk(`EPC_OFF_ISTAT, 32'h0000_0003, 2'h0);
    #1 `CHK("irq_masked", 1'b0, irq_q)
    axi_wr(`EPC_OFF_EVENT_MASK_REG, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 `CHK("irq_set", 1'b1, irq_q)
    axi_wr(`EPC_OFF_ISTAT, 32'h0000_0007);
    repeat (2) @(posedge clk);
    #1 `CHK("irq_clr", 1'b0, irq_q)
    for (i = 0; i < 4; i++) begin
      fire(i);
      expect_take(ev_lvl[i]);
      if (i == 0) `CHK("emu_on", 1'b1, emu_mode_q)
      do_ret();
    end
    #1 `CHK("emu_off", 1'b0, emu_mode_q)
    axi_wr(`EPC_OFF_CTRL, 32'h0000_0000);
    gp_irq <= 9'h001;
    @(posedge clk);
    gp_irq <= 9'h000;
    repeat (10) @(posedge clk);
    #1 `CHK("gp_off", 0, tq.size())
    axi_wr(`EPC_OFF_CTRL, 32'h0000_0003);
    expect_take(4'h1);
    rd_chk(`EPC_OFF_ACTIVE, 32'h0000_0002, 2'h0);
    print_verdict();
  end
endmodule : epc_core_event_unit_tb
`default_nettype wire
